/* logic/aans_defines.svh */
// constants for the accumulate add/sub normalise slice
// assumes a 32-bit datapath and a 5-bit shift field
`ifndef AANS_DEFINES_SVH
`define AANS_DEFINES_SVH
`define AANS_DATA_W      32
`define AANS_SHAMT_W     5
`define AANS_SHAMT_LSB   0
`define AANS_RESULT_RST  32'h0000_0000
`define AANS_LATENCY     1
`endif

/* logic/aans_pkg.sv */
// types for the accumulate add/sub normalise slice
// assumes aans_defines.svh is on the include path
`include "aans_defines.svh"
package aans_pkg;
  // operation select, one code per register-form variant
  typedef enum logic [2:0] {
    AANS_SIGNED_ADD_SHIFT        = 3'h0,
    AANS_UNSIGNED_ADD_SHIFT      = 3'h1,
    AANS_SIGNED_ROUND_ADD_SHIFT  = 3'h2,
    AANS_UNSIGNED_ROUND_ADD_SHIFT = 3'h3,
    AANS_SIGNED_SUB_SHIFT        = 3'h4,
    AANS_UNSIGNED_SUB_SHIFT      = 3'h5,
    AANS_SIGNED_ROUND_SUB_SHIFT  = 3'h6,
    AANS_UNSIGNED_ROUND_SUB_SHIFT = 3'h7
  } aans_op_t;

  // one request from operand read
  typedef struct packed {
    aans_op_t                  op;
    logic [`AANS_DATA_W-1:0]   dest_val;
    logic [`AANS_DATA_W-1:0]   first_source_reg;
    logic [`AANS_DATA_W-1:0]   shift_source_reg;
  } aans_req_t;

  // one result towards writeback
  typedef struct packed {
    logic                      valid;
    logic [`AANS_DATA_W-1:0]   value;
  } aans_res_t;
endpackage

/* logic/aans_shifter.sv */
// right shifter, arithmetic or logical, by a five-bit amount
// purely combinational; the caller registers the result
`timescale 1ns/1ps
module aans_shifter #(
  parameter int DATA_W  = 32,
  parameter int SHAMT_W = 5
) (
  // operand and control
  input  wire logic [DATA_W-1:0]  value_in,
  input  wire logic [SHAMT_W-1:0] shamt_in,
  input  wire logic               arith_in,
  // shifted value
  output logic      [DATA_W-1:0]  value_out
);
  // sign fill only when arithmetic; otherwise zero fill
  always_comb begin
    if (arith_in) begin
      value_out = DATA_W'($signed(value_in) >>> shamt_in);
    end else begin
      value_out = value_in >> shamt_in;
    end
  end
endmodule

/* logic/aans_core.sv */
// accumulate add/sub with normalising right shift and optional rounding
// sits between operand read and writeback; core clock, sync reset
// expects one request word per valid cycle; answers one cycle later
`timescale 1ns/1ps
`include "aans_defines.svh"
module aans_core
  import aans_pkg::*;
#(
  parameter int DATA_W  = `AANS_DATA_W,
  parameter int SHAMT_W = `AANS_SHAMT_W
) (
  // clock and reset
  input  wire logic      ref_clk_in,
  input  wire logic      rst_in,
  // request from operand read
  input  wire logic      req_valid_in,
  input  wire aans_req_t req_in,
  // result to writeback
  output aans_res_t      res_out
);
  // elaboration checks; the struct fixes the word width
  if (DATA_W != `AANS_DATA_W) begin : g_check_data_w
    $error("aans_core: DATA_W must match the request struct");
  end
  // the shift field must match the struct and span the whole word
  if (SHAMT_W != `AANS_SHAMT_W || (2 ** SHAMT_W) != DATA_W) begin : g_check_shamt_w
    $error("aans_core: SHAMT_W must address every bit of the word");
  end
  // one register stage only; a deeper pipeline needs another result path
  if (`AANS_LATENCY != 1) begin : g_check_latency
    $error("aans_core: only a single result stage is built");
  end

  // pull the shift amount out of the shift source word
  // upper bits are ignored on purpose, so callers may leave them dirty
  function automatic logic [SHAMT_W-1:0] shift_amount(input logic [DATA_W-1:0] word);
    shift_amount = word[`AANS_SHAMT_LSB +: SHAMT_W];
  endfunction

  // half of the shift weight, zero for a zero shift
  function automatic logic [DATA_W-1:0] round_const(input logic [SHAMT_W-1:0] sh);
    logic [DATA_W-1:0] one;
    one = {{(DATA_W-1){1'b0}}, 1'b1};
    if (sh == '0) begin
      round_const = '0;
    end else begin
      round_const = one << (sh - SHAMT_W'(1));
    end
  endfunction

  // wrapping add or subtract; carry or borrow out of the top is lost
  function automatic logic [DATA_W-1:0] add_or_sub(
    input logic [DATA_W-1:0] acc,
    input logic [DATA_W-1:0] src,
    input logic              sub
  );
    if (sub) begin
      add_or_sub = acc - src;
    end else begin
      add_or_sub = acc + src;
    end
  endfunction

  // decoded controls
  logic [SHAMT_W-1:0] shamt;
  logic               is_sub;
  logic               is_round;
  logic               is_arith;
  // arithmetic stages ahead of the shifter
  logic [DATA_W-1:0]  base;
  logic [DATA_W-1:0]  rnd;
  logic [DATA_W-1:0]  sum;
  logic [DATA_W-1:0]  shifted;
  // result register and its next value
  aans_res_t          res_reg;
  aans_res_t          res_next;

  // decode the operation code into the three datapath controls
  // each item sets all three, so no control leaks from one code to another
  always_comb begin
    shamt    = shift_amount(req_in.shift_source_reg);
    is_sub   = 1'b0;
    is_round = 1'b0;
    is_arith = 1'b0;
    case (req_in.op)
      // plain signed add, kept so the code space is complete
      AANS_SIGNED_ADD_SHIFT: begin
        is_sub   = 1'b0;
        is_round = 1'b0;
        is_arith = 1'b1;
      end

      AANS_UNSIGNED_ADD_SHIFT: begin
        is_sub   = 1'b0;
        is_round = 1'b0;
        is_arith = 1'b0;
      end

      AANS_SIGNED_ROUND_ADD_SHIFT: begin
        is_sub   = 1'b0;
        is_round = 1'b1;
        is_arith = 1'b1;
      end

      AANS_UNSIGNED_ROUND_ADD_SHIFT: begin
        is_sub   = 1'b0;
        is_round = 1'b1;
        is_arith = 1'b0;
      end

      AANS_SIGNED_SUB_SHIFT: begin
        is_sub   = 1'b1;
        is_round = 1'b0;
        is_arith = 1'b1;
      end

      AANS_UNSIGNED_SUB_SHIFT: begin
        is_sub   = 1'b1;
        is_round = 1'b0;
        is_arith = 1'b0;
      end

      AANS_SIGNED_ROUND_SUB_SHIFT: begin
        is_sub   = 1'b1;
        is_round = 1'b1;
        is_arith = 1'b1;
      end

      AANS_UNSIGNED_ROUND_SUB_SHIFT: begin
        is_sub   = 1'b1;
        is_round = 1'b1;
        is_arith = 1'b0;
      end

      // unreachable with a three-bit code; all controls off
      default: begin
        is_sub   = 1'b0;
        is_round = 1'b0;
        is_arith = 1'b0;
      end
    endcase
  end

  // wraps at 32 bits
  // first stage, destination plus or minus the first source
  always_comb begin
    base = add_or_sub(req_in.dest_val, req_in.first_source_reg, is_sub);
  end

  // zero weight otherwise
  // rounding weight only for the rounding codes
  // the weight is added after the add/sub, so both wrap independently
  always_comb begin
    if (is_round) begin
      rnd = round_const(shamt);
    end else begin
      rnd = '0;
    end
  end

  // second wrapping stage
  // carries out of the top are dropped before the shift, as the core does
  always_comb begin
    sum = add_or_sub(base, rnd, 1'b0);
  end

  // sign fill when arithmetic
  // one shared shifter serves all eight codes
  aans_shifter #(
    .DATA_W  (DATA_W),
    .SHAMT_W (SHAMT_W)
  ) u_shifter (
    .value_in  (sum),
    .shamt_in  (shamt),
    .arith_in  (is_arith),
    .value_out (shifted)
  );

  // result toward destination
  // value holds while idle, so writeback may pick it up late
  always_comb begin
    res_next.valid = req_valid_in;
    if (req_valid_in) begin
      res_next.value = shifted;
    end else begin
      res_next.value = res_reg.value;
    end
  end

  // result register; one cycle from request to result, no back-pressure
  // a fresh request every cycle is taken; nothing is refused
  // reset clears both the pulse and the held value
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      res_reg <= '{valid: 1'b0, value: `AANS_RESULT_RST};
    end else begin
      res_reg <= res_next;
    end
  end

  // output straight from the result register
  assign res_out = res_reg;
endmodule

/* verification/aans_core_checker.sv */
// assertions on the add/sub normalise slice ports
// assumes it is bound onto aans_core, one clock domain
`timescale 1ns/1ps
module aans_core_checker
  import aans_pkg::*;
(
  input wire logic      ref_clk_in,
  input wire logic      rst_in,
  input wire logic      req_valid_in,
  input wire aans_req_t req_in,
  input wire aans_res_t res_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic [31:0] nosh;
  // sum or difference with no rounding and no shift
  assign nosh = req_in.op[2] ? req_in.dest_val - req_in.first_source_reg
                             : req_in.dest_val + req_in.first_source_reg;
  // reference result; signed shift kept apart from the mixed ternary
  function automatic logic [31:0] rv(aans_req_t r);
    logic [31:0] s;
    s = r.op[2] ? r.dest_val - r.first_source_reg : r.dest_val + r.first_source_reg;
    if (r.op[1] && r.shift_source_reg[4:0] != 5'h0)
      s = s + (32'h1 << (r.shift_source_reg[4:0] - 5'h1));
    if (r.op[0])
      return s >> r.shift_source_reg[4:0];
    return $signed(s) >>> r.shift_source_reg[4:0];
  endfunction
  chk_sround_add: assert property (req_valid_in && req_in.op == 3'h2
    |=> res_out.value == rv($past(req_in))) else $error("op 2 result wrong");
  chk_uround_add: assert property (req_valid_in && req_in.op == 3'h3
    |=> res_out.value == rv($past(req_in))) else $error("op 3 result wrong");
  chk_signed_sub: assert property (req_valid_in && req_in.op == 3'h4
    |=> res_out.value == rv($past(req_in))) else $error("op 4 result wrong");
  chk_unsigned_sub: assert property (req_valid_in && req_in.op == 3'h5
    |=> res_out.value == rv($past(req_in))) else $error("op 5 result wrong");
  chk_sround_sub: assert property (req_valid_in && req_in.op == 3'h6
    |=> res_out.value == rv($past(req_in))) else $error("op 6 result wrong");
  chk_uround_sub: assert property (req_valid_in && req_in.op == 3'h7
    |=> res_out.value == rv($past(req_in))) else $error("op 7 result wrong");
  chk_zero_round: assert property (req_valid_in && req_in.op[1]
    && req_in.shift_source_reg[4:0] == 5'h0 |=> res_out.value == $past(nosh))
    else $error("zero shift rounding wrong");
  chk_unsigned_add: assert property (req_valid_in && req_in.op == 3'h1
    |=> res_out.value == rv($past(req_in))) else $error("op 1 result wrong");
  chk_valid_pulse: assert property (1'b1
    |=> res_out.valid == $past(req_valid_in)) else $error("valid timing wrong");
  chk_value_hold: assert property (!req_valid_in
    |=> res_out.value == $past(res_out.value)) else $error("idle value not held");
endmodule
bind aans_core aans_core_checker u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .req_valid_in(req_valid_in), .req_in(req_in), .res_out(res_out));

/* verification/aans_core_bench.sv */
// self-checking bench for the add/sub normalise slice
// assumes one-cycle latency and a valid pulse per request
`timescale 1ns/1ps
module aans_core_bench;
  import aans_pkg::*;
  logic      ref_clk_in;
  logic      rst_in;
  logic      req_valid_in;
  aans_req_t req_in;
  aans_res_t res_out;
  int        err_total;
  int        cmp_count;
  logic [31:0] exp_q[$];
  logic [31:0] last;
  aans_core DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .res_out(res_out));
  // behavioural model, integer shift amount
  function automatic logic [31:0] mdl(aans_req_t r);
    logic [31:0] s;
    int          sh;
    sh = r.shift_source_reg[4:0];
    s = r.op[2] ? r.dest_val - r.first_source_reg : r.dest_val + r.first_source_reg;
    if (r.op[1] && sh > 0) s = s + (32'h1 << (sh - 1));
    if (r.op[0]) return s >> sh;
    return $signed(s) >>> sh;
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  // watchdog, about twice the expected run
  initial begin
    #40000;
    err_total++;
    tally_and_finish();
  end
  // random back-to-back traffic; shift amounts 0 and 31 forced often
  initial begin
    err_total = 0;
    cmp_count = 0;
    last = 32'h0;
    rst_in = 1'b1;
    req_valid_in = 1'b0;
    req_in = '0;
    void'($urandom(32'h0066));
    repeat (5) @(posedge ref_clk_in);
    #2 rst_in = 1'b0;
    for (int i = 0; i < 800; i++) begin
      @(posedge ref_clk_in);
      #1;
      if (exp_q.size() > 0) last = exp_q.pop_front();
      cmp("valid", {31'h0, i > 0 && req_valid_in}, {31'h0, res_out.valid});
      cmp("value", last, res_out.value);
      #1;
      req_valid_in = $urandom_range(0, 3) != 0;
      req_in.op = aans_op_t'($urandom_range(0, 7));
      req_in.dest_val = $urandom;
      req_in.first_source_reg = $urandom;
      req_in.shift_source_reg = $urandom;
      if (i % 4 == 0) req_in.shift_source_reg[4:0] = 5'h0;
      if (i % 4 == 1) req_in.shift_source_reg[4:0] = 5'h1f;
      if (req_valid_in) exp_q.push_back(mdl(req_in));
    end
    // drain the last request before the verdict
    @(posedge ref_clk_in);
    #1;
    if (exp_q.size() > 0) last = exp_q.pop_front();
    cmp("valid", {31'h0, req_valid_in}, {31'h0, res_out.valid});
    cmp("value", last, res_out.value);
    tally_and_finish();
  end
endmodule
